// *** hdl/amci_core.sv ***
/*
 * Application-mode command interpreter of the front-end. Host reaches the
 * shared CSR bank through a word port; the core handles master clear,
 * self-test, read, write and run commands against front-end RAM.
 * Assumes host writes arrive as single-cycle strobes on core_clk.
 */
//
// Behaviour
// - Master clear with run clear reinitialises and restarts without self-test.
// - Master clear with run set runs the self-test before readiness.
// - Master clear drops when initialisation ends, or when the self-test ends if run is set, meaning commands are accepted.
// - Run stays set after master clear drops only when the self-test failed.
// - Error is set when read, write or run names an odd address or one outside RAM.
// - Setting read fetches a RAM word for the host.
// - Setting write stores the host data word in RAM.
// - Run without master clear starts application firmware at the given address.
// - Write uses the address word at offset 4 and the data word at offset 6.
// - Self-test takes about 30 seconds, so a host bounds its polling.
// - All eight CSR words are usable but only low bytes of words 0 and 1 (offsets 0 and 2) interrupt.
// - The address space splits into 16K RAM, 4K ROM and 12K I/O words.
// - The I/O region holds five equal subspaces, one per component.
`timescale 1ns/1ps
module amci_core #(
	parameter int unsigned SELFTEST_CYCLES = 3000000000
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Host CSR port
	input  wire amci_pkg::amci_csr_req_t csr_req,
	input  wire logic                   csr_valid,
	output logic [15:0]                 csr_rdata,
	// Self-test verdict and application start
	input  wire logic                   selftest_fail,
	output logic                        app_start,
	output logic [15:0]                 app_start_addr,
	// Front-end processor events
	output logic                        csr0_irq,
	output logic                        csr2_irq,
	output logic [4:0]                  io_unit_sel
);

	// ---------------------------------------------------------------
	// CSR bank
	// ---------------------------------------------------------------
	logic [15:0]         csr_r [8];
	logic [15:0]         ram_r [amci_pkg::RAM_WORDS];
	amci_pkg::amci_state_t state_r;
	logic [31:0]         cnt_r;
	logic                fail_s1_r;
	logic                fail_s2_r;
	logic [15:0]         rd_word_r;
	// Failed self-test leaves run set; it must not be taken as a command
	logic                hold_run_r;

	amci_pkg::amci_ctrl_t ctrl;
	logic [15:0]         par_addr;
	logic [15:0]         par_data;
	logic                host_ctrl_wr;
	logic                addr_bad;
	logic                ram_hit;
	logic                io_hit;
	logic [15:0]         io_off;
	logic                cnt_done;
	logic [2:0]          word_idx;

	assign word_idx = csr_req.ofs[3:1];
	assign ctrl     = amci_pkg::amci_ctrl_t'(csr_r[0][15:8]);
	assign par_addr = csr_r[2];
	assign par_data = csr_r[3];
	assign host_ctrl_wr = csr_valid && csr_req.wr && word_idx == 3'h0 && csr_req.be[1];
	assign cnt_done = cnt_r == 32'h0;

	// Address map decode
	assign ram_hit  = par_addr <= amci_pkg::RAM_LIMIT;
	assign io_hit   = par_addr >= amci_pkg::IO_START && par_addr <= amci_pkg::IO_END;
	assign io_off   = par_addr - amci_pkg::IO_START;
	assign addr_bad = par_addr[0] || !ram_hit;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_io
			// Equal subspaces of 4096 bytes each
			assign io_unit_sel[gi] = io_hit && (io_off[14:12] == 3'(gi));
		end
	endgenerate

	// Only low-byte writes of words 0 and 1 (offsets 0 and 2) interrupt the processor
	assign csr0_irq = csr_valid && csr_req.wr && word_idx == 3'h0 && csr_req.be[0];
	assign csr2_irq = csr_valid && csr_req.wr && word_idx == 3'h1 && csr_req.be[0];

	assign csr_rdata      = csr_r[word_idx];
	assign app_start_addr = par_addr;

	always_ff @(posedge core_clk) begin
		fail_s1_r <= selftest_fail;
		fail_s2_r <= fail_s1_r;
	end

	// ---------------------------------------------------------------
	// Command sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		app_start <= 1'b0;
		if (rst) begin
			for (int i = 0; i < 8; i++) begin
				csr_r[i] <= 16'h0000;
			end
			state_r <= amci_pkg::ST_IDLE;
			cnt_r   <= 32'h0;
			hold_run_r <= 1'b0;
		end else begin
			if (host_ctrl_wr) hold_run_r <= 1'b0;
			// Host writes land first; device completions override below
			if (csr_valid && csr_req.wr) begin
				if (csr_req.be[0]) csr_r[word_idx][7:0]  <= csr_req.wdata[7:0];
				if (csr_req.be[1]) csr_r[word_idx][15:8] <= csr_req.wdata[15:8];
			end
			if (!cnt_done) cnt_r <= cnt_r - 32'h1;
			unique case (state_r)
				amci_pkg::ST_IDLE, amci_pkg::ST_READY, amci_pkg::ST_APP: begin
					if (ctrl.master_clear_bit) begin
						state_r <= amci_pkg::ST_INIT;
						cnt_r   <= 32'(amci_pkg::INIT_CYCLES);
					end else if (ctrl.write) begin
						// Address from word 2, data from word 3
						if (addr_bad) csr_r[0][8 + amci_pkg::ERROR_BIT] <= 1'b1;
						else ram_r[par_addr[14:1]] <= par_data;
						csr_r[0][8 + amci_pkg::WRITE_BIT] <= 1'b0;
					end else if (ctrl.read) begin
						if (addr_bad) csr_r[0][8 + amci_pkg::ERROR_BIT] <= 1'b1;
						else csr_r[3] <= ram_r[par_addr[14:1]];
						csr_r[0][8 + amci_pkg::READ_BIT] <= 1'b0;
					end else if (ctrl.run && !hold_run_r) begin
						if (addr_bad) csr_r[0][8 + amci_pkg::ERROR_BIT] <= 1'b1;
						else begin
							app_start <= 1'b1;
							state_r   <= amci_pkg::ST_APP;
						end
						csr_r[0][8 + amci_pkg::RUN_BIT] <= 1'b0;
					end
				end
				amci_pkg::ST_INIT: begin
					if (cnt_done) begin
						if (ctrl.run) begin
							state_r <= amci_pkg::ST_TEST;
							cnt_r   <= SELFTEST_CYCLES;
						end else begin
							csr_r[0][8 + amci_pkg::MASTER_CLEAR_BIT_BIT] <= 1'b0;
							state_r <= amci_pkg::ST_READY;
						end
					end
				end
				amci_pkg::ST_TEST: begin
					if (cnt_done) begin
						csr_r[0][8 + amci_pkg::MASTER_CLEAR_BIT_BIT] <= 1'b0;
						csr_r[0][8 + amci_pkg::RUN_BIT]  <= fail_s2_r;
						hold_run_r <= fail_s2_r;
						state_r <= amci_pkg::ST_READY;
					end
				end
				default: state_r <= amci_pkg::ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	master_clear_bit_no_test_a: assert property (state_r == amci_pkg::ST_INIT && cnt_done && !ctrl.run
		|=> !csr_r[0][8 + amci_pkg::MASTER_CLEAR_BIT_BIT]) else $error("master_clear_bit not dropped");
	selftest_entry_a: assert property (state_r == amci_pkg::ST_INIT && cnt_done && ctrl.run
		|=> state_r == amci_pkg::ST_TEST) else $error("self-test skipped");
	test_verdict_a: assert property (state_r == amci_pkg::ST_TEST && cnt_done
		|=> csr_r[0][15] == $past(fail_s2_r)) else $error("bad verdict");
	cmd_error_a: assert property (state_r == amci_pkg::ST_READY && !ctrl.master_clear_bit
		&& (ctrl.read || ctrl.write || (ctrl.run && !hold_run_r)) && addr_bad && !csr_valid
		|=> csr_r[0][8]) else $error("error flag missing");
	read_data_a: assert property (state_r == amci_pkg::ST_READY && !ctrl.master_clear_bit && ctrl.read
		&& !ctrl.write && !addr_bad && !csr_valid
		|=> csr_r[3] == $past(ram_r[par_addr[14:1]])) else $error("read data");
	write_clear_a: assert property (state_r == amci_pkg::ST_READY && !ctrl.master_clear_bit && ctrl.write
		&& !csr_valid |=> !csr_r[0][13]) else $error("write not cleared");
	run_start_a: assert property (state_r == amci_pkg::ST_READY && !ctrl.master_clear_bit && ctrl.run
		&& !ctrl.read && !ctrl.write && !addr_bad && !hold_run_r
		|=> app_start && state_r == amci_pkg::ST_APP) else $error("run missed");
	run_held_a: assert property (hold_run_r && !host_ctrl_wr
		|=> csr_r[0][15] && !app_start) else $error("failed run not held");
	rom_no_io_a: assert property (par_addr >= amci_pkg::ROM_BASE
		|-> io_unit_sel == 5'h00) else $error("rom decoded as io");
	irq_bytes_a: assert property (csr_valid && csr_req.wr && !csr_req.be[0] |-> !csr0_irq
		&& !csr2_irq) else $error("stray irq");
	io_onehot_a: assert property ($onehot0(io_unit_sel)) else $error("io decode");

	cov_init_c: cover property (state_r == amci_pkg::ST_INIT ##[1:20] state_r == amci_pkg::ST_READY);
	cov_write_c: cover property (ctrl.write && !addr_bad ##1 !ctrl.write);
	cov_run_c: cover property (app_start);
	cov_fail_c: cover property (hold_run_r);

endmodule : amci_core

// *** hdl/amci_pkg.sv ***
/*
 * Package for the application-mode command interpreter: control byte
 * fields, parameter word offsets, front-end address map and timing.
 * Assumes a single 100 MHz core clock and a synchronous active-high reset.
 */
package amci_pkg;

	// ---------------------------------------------------------------
	// Control byte fields (bit positions within the high CSR byte)
	// ---------------------------------------------------------------
	localparam int unsigned ERROR_BIT = 0;
	localparam int unsigned RSVD9_BIT = 1;
	localparam int unsigned READ_BIT  = 2;
	localparam int unsigned RSVD11_BIT = 3;
	localparam int unsigned RSVD12_BIT = 4;
	localparam int unsigned WRITE_BIT = 5;
	localparam int unsigned MASTER_CLEAR_BIT_BIT  = 6;
	localparam int unsigned RUN_BIT   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ---------------------------------------------------------------
	// CSR word offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [3:0] CSR_CTRL_OFS = 4'h1;
	localparam logic [3:0] CSR_ADDR_OFS = 4'h4;
	localparam logic [3:0] CSR_DATA_OFS = 4'h6;

	// ---------------------------------------------------------------
	// Front-end address map (byte addresses, 16 bits)
	// ---------------------------------------------------------------
	localparam logic [15:0] RAM_BASE  = 16'h0000;
	localparam logic [15:0] RAM_LIMIT = 16'h7FFF;   // 16K words
	// ROM sits above the I/O region, so the two never overlap
	localparam logic [15:0] ROM_BASE  = 16'hE000;
	localparam logic [15:0] ROM_LIMIT = 16'hFFFF;   // 4K words
	localparam logic [15:0] IO_BASE   = 16'h8000 + 16'h0000;
	localparam logic [15:0] IO_START  = 16'h8000;   // octal 100000
	localparam logic [15:0] IO_END    = 16'hDFFF;   // 12K words
	localparam int unsigned IO_SUB_SHIFT = 12;      // 10000 octal bytes each
	localparam int unsigned IO_UNITS  = 5;
	localparam int unsigned RAM_WORDS = 16384;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_MHZ       = 100;
	localparam int unsigned SELFTEST_S    = 30;
	localparam int unsigned INIT_CYCLES   = 16;
	localparam logic [4:0]  INIT_CNT      = 5'h10;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_INIT  = 3'b001,
		ST_TEST  = 3'b010,
		ST_READY = 3'b011,
		ST_APP   = 3'b100
	} amci_state_t;

	typedef struct packed {
		logic run;
		logic master_clear_bit;
		logic write;
		logic rsvd12;
		logic rsvd11;
		logic read;
		logic rsvd9;
		logic error;
	} amci_ctrl_t;

	typedef struct packed {
		logic        wr;
		logic [3:0]  ofs;
		logic [1:0]  be;
		logic [15:0] wdata;
	} amci_csr_req_t;

endpackage : amci_pkg

// *** verif/amci_host.sv ***
/*
 * Host model: word accesses to the CSR bank and bounded polling of
 * the control byte. Assumes the core takes an access on a valid edge.
 */
`timescale 1ns/1ps
module amci_host (
	// Clock
	input  wire logic               core_clk,
	// CSR port
	output amci_pkg::amci_csr_req_t csr_req,
	output logic                    csr_valid,
	input  wire logic [15:0]        csr_rdata,
	input  wire logic               csr0_irq,
	input  wire logic               csr2_irq
);
	initial begin
		csr_req = '0;
		csr_valid = 1'b0;
	end
	// Bits 9, 11 and 12 are always written as zero by callers
	task automatic acc(input logic wr, input logic [3:0] ofs, input logic [1:0] be,
		input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] ir);
		@(posedge core_clk);
		csr_req <= '{wr, ofs, be, wd};
		csr_valid <= 1'b1;
		@(posedge core_clk);
		rd = csr_rdata;
		ir = {csr2_irq, csr0_irq};
		csr_valid <= 1'b0;
		// Released data must not look stable
		csr_req.wdata <= ~wd;
	endtask : acc
	// Bounded wait, a hung device cannot stall the host
	task automatic poll(input logic [15:0] mask, output logic [15:0] rd);
		int n;
		logic [1:0] ir;
		rd = mask;
		for (n = 0; n < 400 && (rd & mask) != 16'h0000; n++) begin
			acc(1'b0, 4'h0, 2'b11, 16'h0000, rd, ir);
		end
	endtask : poll
endmodule : amci_host

// *** verif/app_mode_control_interface_test.sv ***
/*
 * Self-checking bench for the command interpreter, driven through the
 * host model. Assumes a self-test count of 50 cycles.
 */
`timescale 1ns/1ps
module app_mode_control_interface_test;
	logic                    core_clk = 1'b0;
	logic                    rst = 1'b1;
	logic                    selftest_fail = 1'b0;
	amci_pkg::amci_csr_req_t csr_req;
	logic                    csr_valid, app_start, csr0_irq, csr2_irq;
	logic [15:0]             csr_rdata, app_start_addr, rd;
	logic [4:0]              io_unit_sel;
	logic [1:0]              ir;
	int                      n_mismatch = 0;
	int                      checked = 0;
	int                      cyc = 0;
	always #5 core_clk = ~core_clk;
	amci_core #(.SELFTEST_CYCLES(50)) u_amci_core (.core_clk(core_clk), .rst(rst),
		.csr_req(csr_req), .csr_valid(csr_valid), .csr_rdata(csr_rdata),
		.selftest_fail(selftest_fail), .app_start(app_start),
		.app_start_addr(app_start_addr), .csr0_irq(csr0_irq), .csr2_irq(csr2_irq),
		.io_unit_sel(io_unit_sel));
	amci_host u_amci_host (.core_clk(core_clk), .csr_req(csr_req), .csr_valid(csr_valid),
		.csr_rdata(csr_rdata), .csr0_irq(csr0_irq), .csr2_irq(csr2_irq));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic results();
		$display("checked=%0d mismatches=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : results
	task automatic wr(input logic [3:0] o, input logic [1:0] be, input logic [15:0] d);
		u_amci_host.acc(1'b1, o, be, d, rd, ir);
	endtask : wr
	task automatic fin(input string s);
		$display("test %s done, mismatches %0d", s, n_mismatch);
	endtask : fin
	task automatic t_reset();
		for (int i = 0; i < 8; i++) begin
			u_amci_host.acc(1'b0, 4'(2 * i), 2'b11, 16'h0000, rd, ir);
			chk(rd, 16'h0000);
		end
		fin("reset");
	endtask : t_reset
	task automatic t_master_clear_bit(input logic run, input logic fail);
		@(posedge core_clk) selftest_fail <= fail;
		wr(4'h0, 2'b10, 16'h0000);
		wr(4'h0, 2'b10, {run, 15'h4000});
		// Past init but well inside the self-test
		repeat (30) @(posedge core_clk);
		u_amci_host.acc(1'b0, 4'h0, 2'b11, 16'h0000, rd, ir);
		chk(rd & 16'h4000, {1'b0, run, 14'h0});
		u_amci_host.poll(16'h4000, rd);
		chk(rd & 16'hC000, {run & fail, 15'h0});
		fin("master_clear_bit");
	endtask : t_master_clear_bit
	task automatic t_load();
		wr(4'h4, 2'b11, 16'h0010);
		wr(4'h6, 2'b11, 16'hA5C3);
		wr(4'h0, 2'b10, 16'h2000);
		u_amci_host.poll(16'h2000, rd);
		chk(rd & 16'hFF00, 16'h0000);
		wr(4'h6, 2'b11, 16'h0000);
		wr(4'h0, 2'b10, 16'h0400);
		u_amci_host.poll(16'h0400, rd);
		chk(rd & 16'hFF00, 16'h0000);
		u_amci_host.acc(1'b0, 4'h6, 2'b11, 16'h0000, rd, ir);
		chk(rd, 16'hA5C3);
		fin("load");
	endtask : t_load
	task automatic t_err();
		for (int i = 0; i < 2; i++) begin
			wr(4'h4, 2'b11, i == 0 ? 16'h0011 : 16'h8000);
			wr(4'h0, 2'b10, 16'h0400);
			u_amci_host.poll(16'h0400, rd);
			chk(rd & 16'hFF00, 16'h0100);
			wr(4'h0, 2'b10, 16'h0000);
		end
		fin("error");
	endtask : t_err
	task automatic t_run();
		int n;
		wr(4'h4, 2'b11, 16'h0100);
		wr(4'h0, 2'b10, 16'h8000);
		for (n = 0; n < 10 && app_start !== 1'b1; n++) begin
			@(posedge core_clk);
		end
		chk({15'h0, app_start}, 16'h0001);
		chk(app_start_addr, 16'h0100);
		u_amci_host.poll(16'h8000, rd);
		chk(rd & 16'hFF00, 16'h0000);
		fin("run");
	endtask : t_run
	task automatic t_irq_io();
		wr(4'h0, 2'b01, 16'h0055);
		chk({14'h0, ir}, 16'h0001);
		wr(4'h2, 2'b01, 16'h0033);
		chk({14'h0, ir}, 16'h0002);
		wr(4'h0, 2'b10, 16'h0000);
		chk({14'h0, ir}, 16'h0000);
		for (int i = 0; i < 7; i++) begin
			wr(4'h4, 2'b11, i < 5 ? {1'b1, 3'(i), 12'h000} : (i == 5 ? 16'h7FFE : 16'hE000));
			@(negedge core_clk);
			chk({11'h0, io_unit_sel}, i < 5 ? (16'h0001 << i) : 16'h0000);
		end
		fin("irq_io");
	endtask : t_irq_io
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		t_reset();
		t_master_clear_bit(1'b0, 1'b0);
		t_master_clear_bit(1'b1, 1'b1);
		t_master_clear_bit(1'b1, 1'b0);
		t_load();
		t_err();
		t_run();
		t_irq_io();
		results();
	end
endmodule : app_mode_control_interface_test
